// ---- pkg/adc_cfg_pkg.sv ----
package adc_cfg_pkg;
  localparam int unsigned APB_ADDR_W = 8;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned SAMPLE_W = 8;
  // Register indices; the byte address is four times the index
  localparam logic [APB_ADDR_W-1:0] EXT_CFG_IDX = 8'h09;
  localparam logic [APB_ADDR_W-1:0] Q_OFFSET_IDX = 8'h0A;
  localparam logic [APB_ADDR_W-1:0] STATUS_IDX = 8'h10;
  localparam logic [APB_ADDR_W-1:0] EXT_CFG_ADDR = 8'h24;
  localparam logic [APB_ADDR_W-1:0] Q_OFFSET_ADDR = 8'h28;
  localparam logic [APB_ADDR_W-1:0] STATUS_ADDR = 8'h40;
  localparam logic [REG_W-1:0] EXT_CFG_RESET = 16'h03FF;
  localparam logic [REG_W-1:0] Q_OFFSET_RESET = 16'h007F;
  // Extended configuration fields
  localparam int unsigned TEST_PATTERN_BIT = 15;
  localparam int unsigned TRIM_DISABLE_BIT = 14;
  localparam int unsigned INTERLEAVE_BIT = 13;
  localparam int unsigned INPUT_SELECT_BIT = 12;
  localparam int unsigned LOW_RATE_BIT = 10;
  // Q offset fields
  localparam int unsigned Q_MAG_MSB = 15;
  localparam int unsigned Q_MAG_LSB = 8;
  localparam int unsigned Q_SIGN_BIT = 7;
  localparam int unsigned Q_MAG_W = 8;
  localparam int unsigned Q_OFFSET_STEP_UV = 176;
  localparam int unsigned Q_OFFSET_FULL_MV = 45;
  localparam int unsigned LOW_RATE_LIMIT_MHZ = 900;
  // Status fields
  localparam int unsigned ST_CAL_BUSY = 0;
  localparam int unsigned ST_TRIM_ACTIVE = 1;
  localparam int unsigned ST_OUTPUT_DATA_CLOCK_ON = 2;
  localparam int unsigned ST_PATTERN_ON = 3;
  localparam int unsigned ST_INTERLEAVE = 4;
  localparam int unsigned ST_CAL_DONE = 5;
  localparam int unsigned ST_CAL_COUNT_LSB = 8;
  localparam int unsigned CAL_COUNT_W = 8;
  localparam int unsigned CAL_TRIM_CYCLES_DEF = 64;
  localparam int unsigned CAL_CONV_CYCLES_DEF = 128;
  localparam int unsigned BYTE_W = 8;
  localparam logic [APB_DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    OUT_SDR_DEMUX,
    OUT_DDR_DEMUX,
    OUT_NON_DEMUX
  } out_mode_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] first;
    logic [SAMPLE_W-1:0] second;
    logic over_range;
  } sample_pair_t;

  typedef struct packed {
    sample_pair_t i_bus;
    sample_pair_t q_bus;
  } out_bus_t;

  typedef struct packed {
    logic interleave;
    logic i_conv_from_q;
    logic q_conv_from_q;
    logic double_rate;
  } route_t;

  typedef struct packed {
    logic negative;
    logic [Q_MAG_W-1:0] magnitude;
    logic signed [Q_MAG_W:0] steps;
  } q_offset_t;
endpackage

// ---- verilog/pin_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
  import adc_cfg_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_stable
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      o_stable <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only a level seen on two stages in a row counts
      for (int b = 0; b < WIDTH; b++) begin
        if (s2_reg[b] == s3_reg[b]) begin
          o_stable[b] <= s3_reg[b];
        end
      end
    end
  end
endmodule // pin_sync3
`default_nettype wire

// ---- verilog/test_pattern_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_pattern_gen
  import adc_cfg_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_demux,
  output out_bus_t o_pattern
);
  logic [SAMPLE_W-1:0] step_reg;
  logic [SAMPLE_W-1:0] step_b;

  assign step_b = step_reg + SAMPLE_W'(1);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !i_enable) begin
      step_reg <= '0;
    end else begin
      step_reg <= i_demux ? step_reg + SAMPLE_W'(2) : step_b;
    end
  end

  // Demux modes carry two consecutive steps, non-demux only one
  always_comb begin
    o_pattern.i_bus.first = step_reg;
    o_pattern.i_bus.second = i_demux ? step_b : '0;
    o_pattern.i_bus.over_range = step_reg[0];
    o_pattern.q_bus.first = ~step_reg;
    o_pattern.q_bus.second = i_demux ? ~step_b : '0;
    o_pattern.q_bus.over_range = ~step_reg[0];
  end
endmodule // test_pattern_gen
`default_nettype wire

// ---- verilog/adc_ext_config_and_q_offset_regs.sv ----
// Behaviour
// [R1] Bit 15 swaps converter data for pattern
// [R2] Pattern valid in SDR, DDR, non-demux
// [R3] Bit 14 skips trim, keeps data clock
// [R4] Converter calibration always runs
// [R5] Bit 13 interleaves both converters
// [R6] Bit 13 clear: two independent channels
// [R7] Bit 12 picks interleaved input
// [R8] Bit 10 enables low clock rate settings
// [R9] Bits 15:8 set Q offset magnitude
// [R10] Each code adds one offset step
// [R11] Bit 7 sets Q offset polarity
// [R12] Software writes reserved bits correctly
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_ext_config_and_q_offset_regs
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CAL_TRIM_CYCLES = CAL_TRIM_CYCLES_DEF,
  parameter int unsigned CAL_CONV_CYCLES = CAL_CONV_CYCLES_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_ADDR_W-1:0] i_paddr,
  input wire logic [APB_DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [APB_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cal_pin,
  input wire out_mode_t i_output_mode,
  input wire sample_pair_t i_conv_i,
  input wire sample_pair_t i_conv_q,
  output out_bus_t o_data,
  output route_t o_route,
  output q_offset_t o_q_offset,
  output logic o_low_clock_rate_option,
  output logic o_term_trim_active,
  output logic o_conv_cal_active,
  output logic o_output_data_clock_en
);
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_TRIM,
    CAL_CONV
  } cal_state_t;

  logic [REG_W-1:0] extended_configuration_reg;
  logic [REG_W-1:0] q_channel_offset_reg;
  logic [REG_W-1:0] extended_configuration_next;
  logic [REG_W-1:0] q_channel_offset_next;
  logic [APB_DATA_W-1:0] prdata_next;
  logic [APB_DATA_W-1:0] status_word;
  logic setup_phase;
  logic access_phase;
  logic hit_ext;
  logic hit_qoff;
  logic hit_status;
  logic addr_hit;
  logic wr_ext;
  logic wr_qoff;
  logic test_pattern_select;
  logic termination_trim_disable;
  logic interleave_en;
  logic interleave_input_select;
  logic demux;
  logic cal_pin_stable;
  logic cal_pin_prev_reg;
  logic cal_request;
  logic power_on_cal_reg;
  logic cal_done_reg;
  logic skip_trim_reg;
  logic output_data_clock_en_next;
  logic [CAL_COUNT_W-1:0] cal_count_reg;
  cal_state_t cal_state_reg;
  out_bus_t pattern;
  out_bus_t data_next;

  // APB decode
  assign setup_phase = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  assign hit_ext = (i_paddr == EXT_CFG_ADDR);
  assign hit_qoff = (i_paddr == Q_OFFSET_ADDR);
  assign hit_status = (i_paddr == STATUS_ADDR);
  assign addr_hit = hit_ext || hit_qoff || hit_status;
  assign wr_ext = access_phase && i_pwrite && hit_ext;
  assign wr_qoff = access_phase && i_pwrite && hit_qoff;

  // Zero wait states; status is read only, so writing it is an error
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase && (!addr_hit || (i_pwrite && hit_status));

  // Reserved bits are stored as written and never steer logic
  always_comb begin
    extended_configuration_next = extended_configuration_reg;
    q_channel_offset_next = q_channel_offset_reg;
    if (i_pstrb[0]) begin
      extended_configuration_next[BYTE_W-1:0] = i_pwdata[BYTE_W-1:0];
      q_channel_offset_next[BYTE_W-1:0] = i_pwdata[BYTE_W-1:0];
    end
    if (i_pstrb[1]) begin
      extended_configuration_next[REG_W-1:BYTE_W] = i_pwdata[REG_W-1:BYTE_W];
      q_channel_offset_next[REG_W-1:BYTE_W] = i_pwdata[REG_W-1:BYTE_W];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      extended_configuration_reg <= EXT_CFG_RESET;
    end else if (wr_ext) begin
      extended_configuration_reg <= extended_configuration_next; // R12
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_channel_offset_reg <= Q_OFFSET_RESET;
    end else if (wr_qoff) begin
      q_channel_offset_reg <= q_channel_offset_next;
    end
  end

  // Status word shows live calibration and output state
  always_comb begin
    status_word = RDATA_ZERO;
    status_word[ST_CAL_BUSY] = (cal_state_reg != CAL_IDLE);
    status_word[ST_TRIM_ACTIVE] = o_term_trim_active;
    status_word[ST_OUTPUT_DATA_CLOCK_ON] = o_output_data_clock_en;
    status_word[ST_PATTERN_ON] = test_pattern_select;
    status_word[ST_INTERLEAVE] = interleave_en;
    status_word[ST_CAL_DONE] = cal_done_reg;
    status_word[ST_CAL_COUNT_LSB +: CAL_COUNT_W] = cal_count_reg;
  end

  // Configuration registers are write only and read back as zero
  always_comb begin
    prdata_next = o_prdata;
    if (setup_phase) begin
      prdata_next = RDATA_ZERO;
      if (!i_pwrite && hit_status) begin
        prdata_next = status_word;
      end
    end
  end

  // Read data is captured in the setup cycle so it is a flop output
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_prdata <= RDATA_ZERO;
    end else begin
      o_prdata <= prdata_next;
    end
  end

  // Field decode
  assign test_pattern_select = extended_configuration_reg[TEST_PATTERN_BIT];
  assign termination_trim_disable = extended_configuration_reg[TRIM_DISABLE_BIT];
  assign interleave_en = extended_configuration_reg[INTERLEAVE_BIT];
  assign interleave_input_select = extended_configuration_reg[INPUT_SELECT_BIT];

  // Routing of analog inputs to the two converters
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_route <= '{interleave: 1'b0, i_conv_from_q: 1'b0, q_conv_from_q: 1'b1,
                   double_rate: 1'b0};
    end else if (interleave_en) begin
      o_route.interleave <= 1'b1; // R5
      o_route.double_rate <= 1'b1; // R5
      o_route.i_conv_from_q <= interleave_input_select; // R7
      o_route.q_conv_from_q <= interleave_input_select; // R7
    end else begin
      o_route.interleave <= 1'b0; // R6
      o_route.double_rate <= 1'b0; // R6
      o_route.i_conv_from_q <= 1'b0; // R6
      o_route.q_conv_from_q <= 1'b1; // R6
    end
  end

  // Low clock rate settings are meant for input clocks below the limit
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_low_clock_rate_option <= 1'b0;
    end else begin
      o_low_clock_rate_option <= extended_configuration_reg[LOW_RATE_BIT]; // R8
    end
  end

  // Signed offset in steps of one code each, full range at the top code
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_q_offset <= '0;
    end else begin
      o_q_offset.magnitude <= q_channel_offset_reg[Q_MAG_MSB:Q_MAG_LSB]; // R9
      o_q_offset.negative <= q_channel_offset_reg[Q_SIGN_BIT]; // R11
      if (q_channel_offset_reg[Q_SIGN_BIT]) begin
        o_q_offset.steps <= -$signed({1'b0, q_channel_offset_reg[Q_MAG_MSB:Q_MAG_LSB]}); // R11
      end else begin
        o_q_offset.steps <= $signed({1'b0, q_channel_offset_reg[Q_MAG_MSB:Q_MAG_LSB]}); // R10
      end
    end
  end

  // Output mode; an illegal code is treated as non-demux
  always_comb begin
    unique case (i_output_mode)
      OUT_SDR_DEMUX: demux = 1'b1;
      OUT_DDR_DEMUX: demux = 1'b1;
      OUT_NON_DEMUX: demux = 1'b0;
      default: demux = 1'b0;
    endcase
  end

  test_pattern_gen u_pattern (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(test_pattern_select),
    .i_demux(demux), // R2
    .o_pattern(pattern)
  );

  // Pattern replaces every data bit, over-range included
  always_comb begin
    if (test_pattern_select) begin
      data_next = pattern; // R1
    end else begin
      data_next.i_bus = i_conv_i;
      data_next.q_bus = i_conv_q;
      if (!demux) begin
        data_next.i_bus.second = '0;
        data_next.q_bus.second = '0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_data <= '0;
    end else begin
      o_data <= data_next; // R1
    end
  end

  // Calibration request pin crosses in through three stages
  pin_sync3 #(
    .WIDTH(1)
  ) u_cal_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_cal_pin),
    .o_stable(cal_pin_stable)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cal_pin_prev_reg <= 1'b0;
    end else begin
      cal_pin_prev_reg <= cal_pin_stable;
    end
  end

  // A calibration also runs once after reset, before any pin request
  assign cal_request = (cal_pin_stable && !cal_pin_prev_reg) || power_on_cal_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      power_on_cal_reg <= 1'b1;
    end else if (cal_state_reg != CAL_IDLE) begin
      power_on_cal_reg <= 1'b0;
    end
  end

  // Requests during a running calibration are ignored
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cal_state_reg <= CAL_IDLE;
      cal_count_reg <= '0;
      skip_trim_reg <= 1'b0;
    end else begin
      unique case (cal_state_reg)
        CAL_IDLE: begin
          cal_count_reg <= '0;
          if (cal_request) begin
            // Latched so a write mid-run cannot restart the data clock during the trim
            skip_trim_reg <= termination_trim_disable;
            cal_state_reg <= termination_trim_disable ? CAL_CONV : CAL_TRIM; // R3
          end
        end
        CAL_TRIM: begin
          if (cal_count_reg == CAL_COUNT_W'(CAL_TRIM_CYCLES - 1)) begin
            cal_count_reg <= '0;
            cal_state_reg <= CAL_CONV; // R4
          end else begin
            cal_count_reg <= cal_count_reg + CAL_COUNT_W'(1);
          end
        end
        CAL_CONV: begin
          if (cal_count_reg == CAL_COUNT_W'(CAL_CONV_CYCLES - 1)) begin
            cal_count_reg <= '0;
            cal_state_reg <= CAL_IDLE;
          end else begin
            cal_count_reg <= cal_count_reg + CAL_COUNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cal_done_reg <= 1'b0;
    end else if (cal_request && cal_state_reg == CAL_IDLE) begin
      cal_done_reg <= 1'b0;
    end else if (cal_state_reg == CAL_CONV &&
                 cal_count_reg == CAL_COUNT_W'(CAL_CONV_CYCLES - 1)) begin
      cal_done_reg <= 1'b1;
    end
  end

  assign o_term_trim_active = (cal_state_reg == CAL_TRIM);
  assign o_conv_cal_active = (cal_state_reg == CAL_CONV); // R4

  // Data clock stops for a trimming calibration only
  assign output_data_clock_en_next = (cal_state_reg == CAL_IDLE) || skip_trim_reg; // R3

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_output_data_clock_en <= 1'b1;
    end else begin
      o_output_data_clock_en <= output_data_clock_en_next;
    end
  end
endmodule // adc_ext_config_and_q_offset_regs
`default_nettype wire

// ---- sim/adc_cfg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CAL_TRIM_CYCLES = CAL_TRIM_CYCLES_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_ADDR_W-1:0] i_paddr,
  input wire logic [APB_DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire route_t o_route,
  input wire q_offset_t o_q_offset,
  input wire logic o_low_clock_rate_option,
  input wire logic o_term_trim_active,
  input wire logic o_conv_cal_active,
  input wire logic o_output_data_clock_en
);
  logic wr_ext;
  logic wr_q;
  logic [8:0] trim_cnt_reg;
  // Only full low-half writes count, so partial strobes never arm a check
  assign wr_ext = i_psel && i_penable && i_pwrite && (&i_pstrb[1:0]) && i_paddr == EXT_CFG_ADDR;
  assign wr_q = i_psel && i_penable && i_pwrite && (&i_pstrb[1:0]) && i_paddr == Q_OFFSET_ADDR;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !o_term_trim_active) begin
      trim_cnt_reg <= '0;
    end else begin
      trim_cnt_reg <= trim_cnt_reg + 9'h001;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  trim_len_a: assert property ($fell(o_term_trim_active) |->
    32'(trim_cnt_reg) == CAL_TRIM_CYCLES && o_conv_cal_active) else $error("trim phase length");
  output_data_clock_off_a: assert property ($rose(o_term_trim_active) |=>
    !o_output_data_clock_en) else $error("data clock kept during trim");
  output_data_clock_keep_a: assert property ($rose(o_conv_cal_active) && !$past(o_term_trim_active) |->
    o_output_data_clock_en[*4]) else $error("data clock stopped without trim");
  route_des_a: assert property (wr_ext && i_pwdata[13] |-> ##2
    o_route == {1'b1, {2{$past(i_pwdata[12], 2)}}, 1'b1}) else $error("interleave route");
  route_dual_a: assert property (wr_ext && !i_pwdata[13] |-> ##2
    o_route == 4'b0010) else $error("dual channel route");
  low_rate_a: assert property (wr_ext |-> ##2
    o_low_clock_rate_option == $past(i_pwdata[10], 2)) else $error("low rate option");
  q_mag_sign_a: assert property (wr_q |-> ##2
    {o_q_offset.magnitude, o_q_offset.negative} == $past(i_pwdata[15:7], 2))
    else $error("q offset fields");
  q_steps_a: assert property (o_q_offset.steps == (o_q_offset.negative ?
    -$signed({1'b0, o_q_offset.magnitude}) : $signed({1'b0, o_q_offset.magnitude})))
    else $error("q offset steps");
endmodule // adc_cfg_checker
`default_nettype wire

// ---- sim/adc_ext_config_and_q_offset_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_ext_config_and_q_offset_regs_test;
  import adc_cfg_pkg::*;
  localparam int unsigned TRIM_N = 4;
  localparam int unsigned CONV_N = 8;
  typedef struct packed {
    logic rd;
    logic err;
    logic [31:0] data;
  } note_t;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cal_pin;
  out_mode_t mode;
  sample_pair_t conv_i;
  sample_pair_t conv_q;
  out_bus_t data;
  out_bus_t p0;
  route_t route;
  q_offset_t qoff;
  logic low_rate;
  logic trim_on;
  logic conv_on;
  logic output_data_clock_en;
  int failures;
  int tests_run;
  note_t notes[$];

  adc_ext_config_and_q_offset_regs #(.CAL_TRIM_CYCLES(TRIM_N), .CAL_CONV_CYCLES(CONV_N)) dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cal_pin(cal_pin),
    .i_output_mode(mode), .i_conv_i(conv_i), .i_conv_q(conv_q), .o_data(data),
    .o_route(route), .o_q_offset(qoff), .o_low_clock_rate_option(low_rate),
    .o_term_trim_active(trim_on), .o_conv_cal_active(conv_on),
    .o_output_data_clock_en(output_data_clock_en));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ends one idle edge after the access so the next call never drives psel twice in a step
  // For a read, d is the expected read data; only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    notes.push_back('{!w, err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // f = {pattern, trim off, interleave, input select, low rate}; reserved bits kept legal
  task automatic cfg(input logic [4:0] f);
    apb(1'b1, EXT_CFG_ADDR, {16'($urandom()), f[4:1], 1'b0, f[0], 10'h3FF}, 1'b0);
  endtask

  task automatic cal(input logic skip);
    int t;
    int c;
    int d;
    t = 0;
    c = 0;
    d = 0;
    cfg({1'b0, skip, 3'b000});
    cal_pin <= 1'b1;
    cyc(2);
    cal_pin <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      t += trim_on;
      c += conv_on;
      d += !output_data_clock_en;
    end
    check("trim_cycles", skip ? 0 : TRIM_N, t);
    check("conv_cycles", CONV_N, c);
    check("output_data_clock_stopped", 32'(!skip), 32'(d != 0));
    $display("calibration test done, trim skip %0d", skip);
  endtask

  // Pending notes hold each access's expected pslverr, plus read data for reads; a result appears at every access edge
  always @(posedge clk) begin
    note_t nt;
    if (psel && penable && pready) begin
      nt = notes.pop_front();
      check("pslverr", 32'(nt.err), 32'(pslverr));
      if (nt.rd) begin
        check("prdata", nt.data, prdata);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    cyc(20000);
    failures++;
    end_of_test();
  end

  initial begin
    logic [7:0] m;
    logic s;
    logic [8:0] e;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    cal_pin = 1'b0;
    mode = OUT_SDR_DEMUX;
    conv_i = '0;
    conv_q = '0;
    void'($urandom(32'h9E8CCBE0));
    cyc(6);
    rst <= 1'b0;
    cyc(40);
    check("reset_route", 32'h2, 32'(route));
    check("reset_qoff", 32'h0, 32'(qoff));
    check("reset_low_rate", 32'h0, 32'(low_rate));
    check("pready", 32'h1, 32'(pready));
    // Power-on calibration is over by now: done flag set, data clock running
    apb(1'b0, STATUS_ADDR, (32'h1 << ST_CAL_DONE) | (32'h1 << ST_OUTPUT_DATA_CLOCK_ON), 1'b0);
    apb(1'b0, EXT_CFG_ADDR, 32'h0, 1'b0);
    apb(1'b0, Q_OFFSET_ADDR, 32'h0, 1'b0);
    apb(1'b0, 8'h44, 32'h0, 1'b1);
    apb(1'b1, 8'h2C, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF, 1'b1);
    cyc(1);
    check("route_after_refused", 32'h2, 32'(route));
    $display("bus access test done");
    for (int k = 0; k < 8; k++) begin
      cfg({2'b00, k[2:0]});
      cyc(1);
      check("route", k[2] ? {28'h0, 1'b1, k[1], k[1], 1'b1} : 32'h2, 32'(route));
      check("low_rate", 32'(k[0]), 32'(low_rate));
    end
    $display("route test done");
    for (int k = 0; k < 6; k++) begin
      m = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
      s = 1'($urandom());
      e = s ? 9'(-{1'b0, m}) : {1'b0, m};
      apb(1'b1, Q_OFFSET_ADDR, {16'($urandom()), m, s, 7'h7F}, 1'b0);
      cyc(1);
      check("q_magnitude", 32'(m), 32'(qoff.magnitude));
      check("q_negative", 32'(s), 32'(qoff.negative));
      check("q_steps", {23'h0, e}, {23'h0, qoff.steps});
    end
    // Upper lane alone: magnitude changes, sign bit keeps its last value
    pstrb <= 4'h2;
    apb(1'b1, Q_OFFSET_ADDR, {16'h0, 8'h5A, 8'h00}, 1'b0);
    pstrb <= 4'hF;
    cyc(1);
    check("q_lane1_magnitude", 32'h5A, 32'(qoff.magnitude));
    check("q_lane1_negative", 32'(s), 32'(qoff.negative));
    $display("offset test done");
    repeat (4) begin
      conv_i <= 17'($urandom());
      conv_q <= 17'($urandom());
      cyc(2);
      check("pass_i", 32'(conv_i), 32'(data.i_bus));
      check("pass_q", 32'(conv_q), 32'(data.q_bus));
    end
    cfg(5'b10000);
    for (int md = 0; md < 4; md++) begin
      mode <= out_mode_t'(md);
      cyc(4);
      p0 = data;
      cyc(1);
      check("pat_q", 32'(8'(~data.i_bus.first)), 32'(data.q_bus.first));
      check("pat_or", {30'h0, data.i_bus.first[0], ~data.i_bus.first[0]},
        {30'h0, data.i_bus.over_range, data.q_bus.over_range});
      check("pat_step", 32'(8'(p0.i_bus.first + ((md >= 2) ? 8'h01 : 8'h02))),
        32'(data.i_bus.first));
      check("pat_second", (md >= 2) ? 32'h0 : 32'(8'(data.i_bus.first + 8'h01)),
        32'(data.i_bus.second));
    end
    mode <= OUT_SDR_DEMUX;
    cfg(5'b00000);
    $display("pattern test done");
    cal(1'b1);
    cal(1'b0);
    end_of_test();
  end
endmodule // adc_ext_config_and_q_offset_regs_test

bind adc_ext_config_and_q_offset_regs adc_cfg_checker #(.CAL_TRIM_CYCLES(CAL_TRIM_CYCLES))
  rule_watch (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_route(o_route), .o_q_offset(o_q_offset),
  .o_low_clock_rate_option(o_low_clock_rate_option), .o_term_trim_active(o_term_trim_active),
  .o_conv_cal_active(o_conv_cal_active), .o_output_data_clock_en(o_output_data_clock_en));
`default_nettype wire
